//--- timer_regs.svh
/*
 Register offsets, field positions, reset values and limits of the timer.
 Assumes inclusion by its bare name from the package and the design modules.
*/
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Number of capture/compare channels
`define CH_COUNT 7

// Byte offsets on the register bus, one aligned word each
`define OFS_CONTROL   12'h000
`define OFS_COUNT     12'h004
`define OFS_CCR_BASE  12'h010
`define OFS_CCR_END   12'h028
`define OFS_CHCFG_BASE 12'h030
`define OFS_CHCFG_END  12'h048

// Control word fields
`define CTL_RESET     16'h0000
`define CTL_CLR_BIT   2
`define CTL_FLAG_BIT  0

// Channel configuration word fields
`define CHCFG_CAP_BIT   0
`define CHCFG_LOAD_LSB  1

// Largest count for each counter length
`define MAX_16 16'hFFFF
`define MAX_12 16'h0FFF
`define MAX_10 16'h03FF
`define MAX_8  16'h00FF

`endif

//--- timer_pkg.sv
/*
 Types shared by the timer top module and the latch grouping logic.
 Assumes timer_regs.svh is on the include path.
*/
package timer_pkg;
`include "timer_regs.svh"

   typedef enum logic [1:0] {
      MODE_STOP   = 2'b00,
      MODE_UP     = 2'b01,
      MODE_CONT   = 2'b10,
      MODE_UPDOWN = 2'b11
   } count_mode_t;

   typedef enum logic [1:0] {
      LOAD_WRITE  = 2'b00,
      LOAD_ZERO   = 2'b01,
      LOAD_TURN   = 2'b10,
      LOAD_OWN    = 2'b11
   } load_ctl_t;

   // Same bit layout as the software view of the control word
   typedef struct packed {
      logic        unused15;
      logic [1:0]  latch_grouping;
      logic [1:0]  counter_length;
      logic        unused10;
      logic [1:0]  clock_source_select;
      logic [1:0]  input_divider;
      count_mode_t count_mode;
      logic        unused3;
      logic        timer_clear;
      logic        overflow_irq_enable;
      logic        overflow_irq_flag;
   } ctl_t;

   typedef struct packed {
      logic [15:0] count;
      logic        dir_down;
      logic        overflow;
   } step_t;

   typedef struct packed {
      ctl_t                           ctl;
      logic [15:0]                    count;
      logic                           dir_down;
      logic [2:0]                     div_cnt;
      logic                           prev_ext;
      logic                           prev_aux;
      logic                           prev_sub;
      logic [`CH_COUNT-1:0][15:0]     ccr;
      logic [`CH_COUNT-1:0][15:0]     latch;
      logic [`CH_COUNT-1:0]           cap_mode;
      logic [`CH_COUNT-1:0][1:0]      load_ctl;
      logic [`CH_COUNT-1:0]           equal;
      logic                           irq;
      logic                           pready;
      logic                           pslverr;
      logic [31:0]                    prdata;
   } state_t;
endpackage

//--- latch_group.sv
/*
 Decides in which cycle each compare shadow latch takes its data register.
 Assumes one-cycle count events from the timer core.
*/
`timescale 1ns/100ps
`include "timer_regs.svh"
module latch_group (
   input  wire logic [1:0]                 latch_grouping,
   input  wire logic [`CH_COUNT-1:0][1:0]  latch_load_control,
   input  wire logic                       updown_mode,
   input  wire logic                       zero_evt,
   input  wire logic [`CH_COUNT-1:0]       cmp_evt,
   output      logic [`CH_COUNT-1:0]       load
);
   logic [`CH_COUNT-1:0] own_ok;

   genvar i;
   generate
      for (i = 0; i < `CH_COUNT; i++) begin : g_ch
         always_comb begin
            unique case (timer_pkg::load_ctl_t'(latch_load_control[i]))
               timer_pkg::LOAD_WRITE: own_ok[i] = 1'b1;
               timer_pkg::LOAD_ZERO:  own_ok[i] = zero_evt;
               timer_pkg::LOAD_TURN:  own_ok[i] = zero_evt |
                                          (updown_mode & cmp_evt[0]);
               timer_pkg::LOAD_OWN:   own_ok[i] = cmp_evt[i];
            endcase
         end

         always_comb begin
            if (i == 0 && latch_grouping != 2'b11) begin
               load[i] = own_ok[0];
            end else begin
               unique case (latch_grouping)
                  2'b00: load[i] = own_ok[i];
                  // pairs led by the odd channel
                  2'b01: load[i] = own_ok[(i % 2 == 1 || i == 0) ? i : i - 1];
                  // two triples led by 1 and 4
                  2'b10: load[i] = own_ok[(i <= 3) ? 1 : 4];
                  2'b11: load[i] = own_ok[1];
               endcase
            end
         end
      end
   endgenerate
endmodule

//--- timer_top.sv
/*
 Timer control word, running count and capture/compare data registers
 reached over an APB slave, with compare shadow latches loaded from the data registers.
 Assumes clock source inputs and capture events are synchronous to pclk.
*/
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "timer_regs.svh"
module timer_top #(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   input  wire logic              external_timer_clock,
   input  wire logic              aux_clock,
   input  wire logic              subsystem_clock,
   input  wire logic [6:0]        capture_event,
   output      logic              overflow_irq,
   output      logic [6:0]        compare_equal
);
   timer_pkg::state_t s;
   timer_pkg::state_t n;

   logic                 clk_edge;
   logic [2:0]           div_last;
   logic                 tick;
   logic [15:0]          max_count;
   timer_pkg::step_t     step;
   logic                 zero_evt;
   logic [6:0]           cmp_evt;
   logic [6:0]           load;
   logic                 setup;
   logic                 access;
   logic                 wr;
   logic                 hit_ctl;
   logic                 hit_cnt;
   logic                 hit_ccr;
   logic                 hit_cfg;
   logic [ADDR_W-1:0]    ccr_off;
   logic [ADDR_W-1:0]    cfg_off;
   logic [2:0]           ccr_idx;
   logic [2:0]           cfg_idx;
   logic                 wr_ctl;
   logic                 wr_cnt;
   logic                 do_clear;

   function automatic timer_pkg::step_t count_step(
      input logic [15:0]           cnt,
      input logic                  down,
      input timer_pkg::count_mode_t mode,
      input logic [15:0]           top,
      input logic [15:0]           maxv
   );
      timer_pkg::step_t r;
      r.count    = cnt;
      r.dir_down = down;
      r.overflow = 1'b0;
      unique case (mode)
         timer_pkg::MODE_STOP: begin
            r.count = cnt;
         end
         timer_pkg::MODE_UP: begin
            if (cnt >= top || cnt >= maxv) begin
               r.count    = 16'h0000;
               r.overflow = 1'b1;
            end else begin
               r.count = cnt + 16'h0001;
            end
         end
         timer_pkg::MODE_CONT: begin
            if (cnt >= maxv) begin
               r.count    = 16'h0000;
               r.overflow = 1'b1;
            end else begin
               r.count = cnt + 16'h0001;
            end
         end
         timer_pkg::MODE_UPDOWN: begin
            if (!down && cnt < top && cnt < maxv) begin
               r.count = cnt + 16'h0001;
            end else if (cnt <= 16'h0001) begin
               // Reaching zero on the way down ends the period
               r.count    = 16'h0000;
               r.dir_down = 1'b0;
               r.overflow = down || cnt == 16'h0001;
            end else begin
               r.count    = cnt - 16'h0001;
               r.dir_down = 1'b1;
            end
         end
      endcase
      return r;
   endfunction

   always_comb begin
      unique case (s.ctl.clock_source_select)
         2'b00: clk_edge = external_timer_clock & ~s.prev_ext;
         2'b01: clk_edge = aux_clock & ~s.prev_aux;
         2'b10: clk_edge = subsystem_clock & ~s.prev_sub;
         2'b11: clk_edge = ~external_timer_clock & s.prev_ext;
      endcase
   end

   // divider period of 1, 2, 4 or 8 edges
   assign div_last = 3'((4'h1 << s.ctl.input_divider) - 4'h1);
   assign tick = (s.ctl.count_mode != timer_pkg::MODE_STOP) & clk_edge &
                 (s.div_cnt == div_last);

   always_comb begin
      unique case (s.ctl.counter_length)
         2'b00: max_count = `MAX_16;
         2'b01: max_count = `MAX_12;
         2'b10: max_count = `MAX_10;
         2'b11: max_count = `MAX_8;
      endcase
   end

   assign step = count_step(s.count, s.dir_down, s.ctl.count_mode,
                            s.latch[0], max_count);
   assign zero_evt = tick & (step.count == 16'h0000);

   genvar gi;
   generate
      for (gi = 0; gi < `CH_COUNT; gi++) begin : g_cmp
         assign cmp_evt[gi] = tick & (step.count == s.latch[gi]);
      end
   endgenerate

   latch_group u_group (
      .latch_grouping     (s.ctl.latch_grouping),
      .latch_load_control (s.load_ctl),
      .updown_mode        (s.ctl.count_mode == timer_pkg::MODE_UPDOWN),
      .zero_evt           (zero_evt),
      .cmp_evt            (cmp_evt),
      .load               (load)
   );

   // Register decode, taken from the address held through the transfer
   assign setup   = psel & ~penable;
   assign access  = psel & penable & s.pready;
   assign wr      = access & pwrite & ~s.pslverr;
   assign hit_ctl = paddr == `OFS_CONTROL;
   assign hit_cnt = paddr == `OFS_COUNT;
   assign ccr_off = paddr - `OFS_CCR_BASE;
   assign cfg_off = paddr - `OFS_CHCFG_BASE;
   assign hit_ccr = paddr >= `OFS_CCR_BASE && paddr <= `OFS_CCR_END &&
                    paddr[1:0] == 2'h0;
   assign hit_cfg = paddr >= `OFS_CHCFG_BASE && paddr <= `OFS_CHCFG_END &&
                    paddr[1:0] == 2'h0;
   assign ccr_idx = ccr_off[4:2];
   assign cfg_idx = cfg_off[4:2];
   assign wr_ctl  = wr & hit_ctl;
   assign wr_cnt  = wr & hit_cnt;
   assign do_clear = wr_ctl & pwdata[`CTL_CLR_BIT];

   always_comb begin
      n = s;
      n.prev_ext = external_timer_clock;
      n.prev_aux = aux_clock;
      n.prev_sub = subsystem_clock;

      if (s.ctl.count_mode != timer_pkg::MODE_STOP && clk_edge) begin
         n.div_cnt = tick ? 3'h0 : s.div_cnt + 3'h1;
      end
      if (tick) begin
         n.count    = step.count;
         n.dir_down = step.dir_down;
      end

      if (wr_ctl) begin
         n.ctl = timer_pkg::ctl_t'(pwdata[15:0]);
      end
      n.ctl.timer_clear = 1'b0;
      // overflow sets the flag, winning over a software clear
      if (tick && step.overflow) begin
         n.ctl.overflow_irq_flag = 1'b1;
      end
      if (wr_cnt) begin
         n.count = pwdata[15:0];
      end
      // clear resets count, divider and direction
      if (do_clear) begin
         n.count    = 16'h0000;
         n.div_cnt  = 3'h0;
         n.dir_down = 1'b0;
      end

      if (wr && hit_cfg) begin
         n.cap_mode[cfg_idx] = pwdata[`CHCFG_CAP_BIT];
         n.load_ctl[cfg_idx] = pwdata[`CHCFG_LOAD_LSB +: 2];
      end
      if (wr && hit_ccr) begin
         n.ccr[ccr_idx] = pwdata[15:0];
      end
      for (int i = 0; i < `CH_COUNT; i++) begin
         // capture wins over a software write
         if (s.cap_mode[i] && capture_event[i]) begin
            n.ccr[i] = s.count;
         end
         // shadow latch takes the data register
         if (load[i] && !s.cap_mode[i]) begin
            n.latch[i] = s.ccr[i];
         end
         n.equal[i] = s.count == s.latch[i];
      end

      n.irq = n.ctl.overflow_irq_flag & n.ctl.overflow_irq_enable;

      // Zero-wait slave: read data is sampled in the setup cycle, write data in the access cycle
      n.pready  = setup;
      n.pslverr = setup & ~(hit_ctl | hit_cnt | hit_ccr | hit_cfg);
      n.prdata  = 32'h0000_0000;
      if (setup) begin
         if (hit_ctl) begin
            n.prdata[15:0] = s.ctl;
         end else if (hit_cnt) begin
            n.prdata[15:0] = s.count;
         end else if (hit_ccr) begin
            n.prdata[15:0] = s.ccr[ccr_idx];
         end else if (hit_cfg) begin
            n.prdata[`CHCFG_CAP_BIT] = s.cap_mode[cfg_idx];
            n.prdata[`CHCFG_LOAD_LSB +: 2] = s.load_ctl[cfg_idx];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign prdata        = s.prdata;
   assign pready        = s.pready;
   assign pslverr       = s.pslverr;
   assign overflow_irq  = s.irq;
   assign compare_equal = s.equal;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic no_wr;
   assign no_wr = !wr_ctl && !wr_cnt;

   chk_irq_gate: assert property (
      overflow_irq == (s.ctl.overflow_irq_flag & s.ctl.overflow_irq_enable))
      else $error("Interrupt not gated by flag and enable");
   chk_clear_effect: assert property (
      do_clear |=> s.count == 16'h0000 && s.div_cnt == 3'h0 && !s.dir_down)
      else $error("Clear did not reset counter state");
   chk_clear_read: assert property (
      setup && hit_ctl && !pwrite |=> prdata[`CTL_CLR_BIT] == 1'b0)
      else $error("Clear bit read as one");
   chk_stop_hold: assert property (
      s.ctl.count_mode == timer_pkg::MODE_STOP && no_wr |=> $stable(s.count))
      else $error("Count moved while stopped");
   chk_tick_only: assert property (
      !tick && no_wr |=> $stable(s.count))
      else $error("Count moved without a divided tick");
   chk_cont_wrap: assert property (
      tick && s.ctl.count_mode == timer_pkg::MODE_CONT &&
      s.count == max_count && no_wr |=> s.count == 16'h0000)
      else $error("Continuous count did not wrap at maximum");
   chk_up_restart: assert property (
      tick && s.ctl.count_mode == timer_pkg::MODE_UP &&
      s.count == s.latch[0] && no_wr |=> s.count == 16'h0000)
      else $error("Up count did not restart at latch zero");
   chk_updown_turn: assert property (
      tick && s.ctl.count_mode == timer_pkg::MODE_UPDOWN && !s.dir_down &&
      s.count == s.latch[0] && s.count > 16'h0001 && s.count < max_count &&
      no_wr |=> s.dir_down && s.count == $past(s.count) - 16'h0001)
      else $error("Up/down count did not turn at latch zero");
   chk_flag_set: assert property (
      tick && step.overflow |=> s.ctl.overflow_irq_flag)
      else $error("Overflow did not set the flag");
   chk_count_read: assert property (
      setup && hit_cnt && !pwrite |=> prdata[15:0] == $past(s.count))
      else $error("Count read wrong");
   chk_capture_copy: assert property (
      s.cap_mode[1] && capture_event[1] |=> s.ccr[1] == $past(s.count))
      else $error("Capture did not copy the count");
   chk_shadow_load: assert property (
      load[2] && !s.cap_mode[2] |=> s.latch[2] == $past(s.ccr[2]))
      else $error("Shadow latch did not load");
   chk_equal_latch: assert property (
      s.latch[3] != s.ccr[3] && s.count == s.latch[3] |=> compare_equal[3])
      else $error("Compare does not follow the shadow latch");
   chk_group_pair: assert property (
      s.ctl.latch_grouping == 2'b01 |-> load[2] == load[1] &&
      load[6] == load[5])
      else $error("Paired latches loaded apart");
   chk_group_triple: assert property (
      s.ctl.latch_grouping == 2'b10 |-> load[3] == load[1] &&
      load[6] == load[4])
      else $error("Grouped latches loaded apart");
   chk_group_all: assert property (
      s.ctl.latch_grouping == 2'b11 |-> load == {7{load[1]}})
      else $error("All-group latches loaded apart");
   chk_group_none: assert property (
      s.ctl.latch_grouping == 2'b00 && s.load_ctl[2] == 2'b01 &&
      s.load_ctl[1] == 2'b00 |-> load[2] == zero_evt)
      else $error("Independent latch followed another channel");
   chk_load_zero: assert property (
      s.ctl.latch_grouping == 2'b00 && s.load_ctl[4] == 2'b01 |->
      load[4] == zero_evt)
      else $error("Load on zero mistimed");
   chk_len_eight: assert property (
      s.ctl.counter_length == 2'b11 |-> max_count == 16'h00FF)
      else $error("Eight-bit length maximum wrong");
   chk_src_inv: assert property (
      s.ctl.clock_source_select == 2'b11 && s.prev_ext &&
      !external_timer_clock |-> clk_edge)
      else $error("Inverted source edge missed");

   cov_cont_wrap: cover property (
      tick && s.ctl.count_mode == timer_pkg::MODE_CONT && step.overflow);
   cov_updown_turn: cover property (tick && step.dir_down && !s.dir_down);
   cov_capture: cover property (s.cap_mode[1] && capture_event[1]);
   cov_pair_load: cover property (s.ctl.latch_grouping == 2'b01 && load[1]);
endmodule

//--- timer_top_tb.sv
/*
 Self-checking bench for the timer: register access, count modes, clear,
 capture and latch grouping through the APB port.
 Assumes timer_top and timer_pkg are compiled first; aux and subsystem
 clocks are made here, synchronous to pclk, toggling every pclk cycle.
*/
`timescale 1ns/100ps
module timer_top_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_clk = 1'b0;
   logic        aux_clk = 1'b0;
   logic        sub_clk = 1'b0;
   logic [6:0]  cap_evt = 7'h00;
   logic        overflow_irq;
   logic [6:0]  compare_equal;
   int          err_count = 0;
   int          cmp_count = 0;
   logic [31:0] rv;
   logic        re;

   typedef struct packed {
      logic [11:0] a;
      logic [15:0] d;
      logic [15:0] x;
      logic        e;
   } row_t;
   row_t rows [5];
   logic [4:0] grp_exp [4];
   logic [1:0] grp_code [4];

   timer_top i_timer_top (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .external_timer_clock (ext_clk),
      .aux_clock            (aux_clk),
      .subsystem_clock      (sub_clk),
      .capture_event        (cap_evt),
      .overflow_irq         (overflow_irq),
      .compare_equal        (compare_equal)
   );

   always #10 pclk = ~pclk;

   // Source clocks give one rising edge every two pclk cycles
   always @(posedge pclk) begin
      aux_clk <= ~aux_clk;
      sub_clk <= ~sub_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [15:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Outputs launched by the answering edge settle before callers look
      @(negedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] x);
      apb(1'b0, a, 16'h0);
      chk(rv[15:0], x);
   endtask

   task automatic tally_and_finish;
      if (err_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      tally_and_finish();
   end

   initial begin
      rows[0] = '{12'h000, 16'hFFCF, 16'hFFCB, 1'b0};
      rows[1] = '{12'h004, 16'h1234, 16'h1234, 1'b0};
      rows[2] = '{12'h010, 16'h00AB, 16'h00AB, 1'b0};
      rows[3] = '{12'h0FC, 16'hFFFF, 16'h0000, 1'b1};
      rows[4] = '{12'h030, 16'h0006, 16'h0006, 1'b0};
      grp_code = '{2'd3, 2'd1, 2'd2, 2'd0};
      grp_exp  = '{5'b00000, 5'b11000, 5'b11100, 5'b11101};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 16'h0000); // control resets to zero
      rd(12'h004, 16'h0000); // count resets to zero
      // Stop mode keeps the count that the table writes
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].x); // clear bit reads zero
         chk({15'h0, re}, {15'h0, rows[i].e});
      end
      chk({15'h0, overflow_irq}, 16'h0001); // flag and enable set
      wr(12'h000, 16'h0001);
      chk({15'h0, overflow_irq}, 16'h0000); // enable cleared
      rd(12'h004, 16'h1234); // halted count kept
      wr(12'h000, 16'h0004);
      rd(12'h004, 16'h0000); // clear resets count
      wr(12'h000, 16'h0020);
      repeat (20) @(posedge pclk);
      rd(12'h004, 16'h0000); // static external clock gives no ticks
      // Aux source, each divider code over the same span
      for (int k = 0; k < 4; k++) begin
         wr(12'h000, 16'h0004);
         wr(12'h000, 16'h0120 | (k << 6));
         repeat (160) @(posedge pclk);
         wr(12'h000, 16'h0100 | (k << 6));
         apb(1'b0, 12'h004, 16'h0);
         chk({15'h0, (rv[15:0] + 2 >= (80 >> k)) &&
              (rv[15:0] <= (80 >> k) + 2)}, 16'h0001); // rate
         rd(12'h004, rv[15:0]); // stopped count holds
      end
      // Eight-bit continuous count wraps from FF
      wr(12'h000, 16'h0004);
      wr(12'h004, 16'h00F0);
      wr(12'h000, 16'h1A22);
      repeat (100) @(posedge pclk);
      chk({15'h0, overflow_irq}, 16'h0001); // wrap sets flag
      wr(12'h000, 16'h1A03);
      apb(1'b0, 12'h004, 16'h0);
      chk(rv[15:8], 16'h0000); // count bounded by length
      // Up and up/down count stay at or under latch zero
      wr(12'h030, 16'h0000); // latch zero follows its data at once
      for (int m = 1; m < 4; m += 2) begin
         wr(12'h000, 16'h0004);
         wr(12'h010, 16'h0008);
         wr(12'h000, 16'h0202 | (m << 4));
         repeat (200) @(posedge pclk);
         chk({15'h0, overflow_irq}, 16'h0001); // restart or return to zero sets flag
         wr(12'h000, 16'h0203); // idle timer left stopped
         apb(1'b0, 12'h004, 16'h0);
         chk({15'h0, rv[15:0] <= 16'h0008}, 16'h0001);
      end
      // Capture copies the stopped count into data register 1
      wr(12'h000, 16'h6000);
      wr(12'h004, 16'h0ABC);
      wr(12'h034, 16'h0003);
      wr(12'h03C, 16'h0002);
      @(posedge pclk);
      cap_evt <= 7'h02;
      @(posedge pclk);
      cap_evt <= 7'h00;
      rd(12'h014, 16'h0ABC); // capture takes the count
      for (int c = 2; c < 7; c++)
         wr(12'h010 + 4 * c, 16'h0ABC);
      // Each grouping code decides which latches follow their data
      for (int g = 0; g < 4; g++) begin
         wr(12'h000, {1'b0, grp_code[g], 13'h0});
         repeat (4) @(posedge pclk);
         chk({11'h0, compare_equal[6:2]}, {11'h0, grp_exp[g]});
      end
      // Reset in mid-run returns control, count and settings to zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 16'h0000); // control back to zero
      rd(12'h004, 16'h0000); // count back to zero
      rd(12'h034, 16'h0000); // capture setting back to zero
      tally_and_finish();
   end
endmodule
